//--- src/acp_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: 200 MHz system clock
// Notes: times kept in ns, cycle counts derived from them
package acp_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int CONV_TIME_NS = 3000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_TIME_NS = 5000;
    localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_W = 14;
    localparam int CTRL_W = 4;
    localparam int PD_BIT = 3;
    localparam int BANK_BIT = 2;
    localparam int CHAN_LSB = 0;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic [1:0] PTR_RESET = 2'h0;
    localparam int FIFO_DEPTH = 32;

    typedef struct packed {
        logic pd;
        logic bank;
        logic [1:0] nchan_m1;
    } acp_mode_s;

    typedef struct packed {
        logic [1:0] chan;
        logic [DATA_W-1:0] data;
    } acp_result_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_DONE
    } acp_state_e;
endpackage : acp_pkg

//--- src/acp_fifo.sv
// Purpose: synchronous valid/ready FIFO for conversion results
// Assumes: single clock, depth a power of two
// Notes: full and empty exact; reads of an empty FIFO are refused
`timescale 1ns/1ps
`default_nettype none
module acp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // write side
    input wire logic i_wr_valid,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_wr_ready,
    // read side
    output logic o_rd_valid,
    output logic [WIDTH-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("acp_fifo: bad depth");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;

    always_comb begin
        o_wr_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
        o_rd_valid = wp_q != rp_q;
        o_rd_data = mem_q[rp_q[AW-1:0]];
        push = i_wr_valid && o_wr_ready;
        pop = o_rd_valid && i_rd_ready;
        wp_d = push ? wp_q + (AW+1)'(1) : wp_q;
        rp_d = pop ? rp_q + (AW+1)'(1) : rp_q;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    // storage needs no reset
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= i_wr_data;
        end
    end
endmodule : acp_fifo
`default_nettype wire

//--- src/acp_ctrl.sv
// Purpose: digital control of a four-channel sampling converter
// Assumes: async pins resynchronised; analog results arrive on i_sample_*
// Notes: results also streamed through a 32-word FIFO
//
// Functional notes
// RULE1 - host supplies clock up to 16MHz
// RULE2 - power-on leaves done output high
// RULE3 - reset mode: bank A, one channel
// RULE4 - host waits 5us reset before converting
// RULE5 - result memory undefined after power-up
// RULE6 - mode bit three high means power-down
// RULE7 - power-down acts at write end edge
// RULE8 - power-down stops converter, interface stays
// RULE9 - bit three low wakes into coded mode
// RULE10 - host waits wake-up delay before converting
// RULE11 - results coded twos complement
// RULE12 - external demux issues four reads, latch
// RULE13 - demux holds select low whole sequence
// RULE14 - two-bit select picks latched read
// RULE15 - each channel 3us, four-entry memory
// RULE16 - control word taken at write end
// RULE17 - sample at start rise, done after last
// RULE18 - first read clears done, pointer wraps
// RULE19 - host avoids start during power-down
`timescale 1ns/1ps
`default_nettype none
module acp_ctrl #(
    parameter int CONV_CYCLES = acp_pkg::CONV_CYCLES,
    parameter int FIFO_DEPTH = acp_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // parallel interface pins
    input wire logic i_chip_select_n,
    input wire logic i_write_n,
    input wire logic i_read_n,
    input wire logic i_convert_start_n,
    input wire logic [acp_pkg::CTRL_W-1:0] i_control_word_bits,
    output logic [acp_pkg::DATA_W-1:0] o_result_data_bus,
    output logic o_result_data_oe,
    output logic o_conv_done_n,
    // analog side: sampled twos-complement codes per channel
    input wire logic [4*acp_pkg::DATA_W-1:0] i_sample_bank_a,
    input wire logic [4*acp_pkg::DATA_W-1:0] i_sample_bank_b,
    // status and control to analog
    output logic o_power_down,
    output logic o_hold,
    output logic o_bank_b,
    output logic [1:0] o_active_channel,
    // result stream
    output logic o_stream_valid,
    output logic [acp_pkg::DATA_W+1:0] o_stream_data,
    input wire logic i_stream_ready
);
    localparam int DW = acp_pkg::DATA_W;
    localparam int CW = $clog2(CONV_CYCLES + 1);
    initial begin
        if (CONV_CYCLES < 1) $error("acp_ctrl: CONV_CYCLES must be >= 1");
        if (FIFO_DEPTH < 2) $error("acp_ctrl: FIFO_DEPTH must be >= 2");
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    // strobes idle high after reset, so no false edge follows it
    logic [3:0] s1_q, s2_q, s3_q;
    // control bits need no edge, only a stable value at capture
    logic [3:0] cw1_q, cw2_q;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= 4'hF;
            s2_q <= 4'hF;
            s3_q <= 4'hF;
            cw1_q <= 4'h0;
            cw2_q <= 4'h0;
        end else begin
            s1_q <= {i_chip_select_n, i_write_n, i_read_n, i_convert_start_n};
            s2_q <= s1_q;
            s3_q <= s2_q;
            cw1_q <= i_control_word_bits;
            cw2_q <= cw1_q;
        end
    end

    logic wr_act, wr_act_p;
    logic rd_act, rd_act_p;
    logic wr_end, rd_fall, rd_rise, cvs_rise;
    always_comb begin
        // write active only while both strobes low; end = either rises
        wr_act = !s2_q[3] && !s2_q[2];
        wr_act_p = !s3_q[3] && !s3_q[2];
        rd_act = !s2_q[3] && !s2_q[1];
        rd_act_p = !s3_q[3] && !s3_q[1];
        wr_end = wr_act_p && !wr_act; // RULE16
        rd_fall = rd_act && !rd_act_p;
        rd_rise = rd_act_p && !rd_act;
        cvs_rise = s2_q[0] && !s3_q[0];
    end

    // ****************************************
    // mode register
    // ****************************************
    acp_pkg::acp_mode_s mode_q, mode_d;
    always_comb begin
        mode_d = mode_q;
        if (wr_end) begin
            // capture lags strobes by sync depth; data held by host
            mode_d = acp_pkg::acp_mode_s'(cw2_q); // RULE6 RULE7 RULE9
        end
    end
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_q <= acp_pkg::acp_mode_s'(acp_pkg::MODE_RESET); // RULE3
        end else begin
            mode_q <= mode_d;
        end
    end

    // ****************************************
    // conversion sequencer and memory
    // ****************************************
    function automatic logic [DW-1:0] pick(
        input logic [4*DW-1:0] bank,
        input logic [1:0] idx
    );
        pick = bank[idx*DW +: DW];
    endfunction : pick

    acp_pkg::acp_state_e st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [1:0] ch_q, ch_d;
    logic [1:0] nch_q, nch_d;
    logic [1:0] ptr_q, ptr_d;
    logic bank_q, bank_d;
    logic done_n_q, done_n_d;
    logic wr_mem;
    logic [DW-1:0] mem_q [4];
    logic [DW-1:0] smp;
    logic [DW-1:0] dout_q, dout_d;
    logic oe_q, oe_d;
    logic push_v;
    logic fifo_rdy;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        ch_d = ch_q;
        nch_d = nch_q;
        bank_d = bank_q;
        // read edges first: a coinciding done or start must win
        done_n_d = rd_fall ? 1'b1 : done_n_q; // RULE18
        ptr_d = ptr_q;
        if (rd_rise) begin
            ptr_d = (ptr_q == nch_q) ? 2'h0 : ptr_q + 2'h1; // RULE18
        end
        wr_mem = 1'b0;
        smp = bank_q ? pick(i_sample_bank_b, ch_q)
                     : pick(i_sample_bank_a, ch_q); // RULE11
        unique case (st_q)
            acp_pkg::ST_IDLE: begin
                // starts ignored while powered down
                if (cvs_rise && !mode_q.pd) begin // RULE8 RULE17
                    st_d = acp_pkg::ST_CONV;
                    cnt_d = '0;
                    ch_d = 2'h0;
                    nch_d = mode_q.nchan_m1;
                    // bank and count latched: a sequence keeps its mode
                    bank_d = mode_q.bank;
                    ptr_d = acp_pkg::PTR_RESET;
                end
            end
            acp_pkg::ST_CONV: begin
                // power-down cuts the sequence; the channel in progress is lost, finished ones stay in memory and stream
                if (mode_q.pd) begin
                    st_d = acp_pkg::ST_IDLE; // RULE7 RULE8
                end else if (cnt_q == CW'(CONV_CYCLES - 1)) begin // RULE15
                    wr_mem = 1'b1;
                    cnt_d = '0;
                    if (ch_q == nch_q) begin
                        st_d = acp_pkg::ST_DONE;
                    end else begin
                        ch_d = ch_q + 2'h1;
                    end
                end else begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
            acp_pkg::ST_DONE: begin
                // one cycle here lets the last result land first
                done_n_d = 1'b0; // RULE17
                st_d = acp_pkg::ST_IDLE;
            end
        endcase
        oe_d = rd_act; // rd_act already needs select low
        dout_d = rd_fall ? mem_q[ptr_q] : dout_q;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= acp_pkg::ST_IDLE;
            cnt_q <= '0;
            ch_q <= 2'h0;
            nch_q <= 2'h0;
            bank_q <= 1'b0;
            done_n_q <= 1'b1; // RULE2
            ptr_q <= acp_pkg::PTR_RESET;
            dout_q <= '0;
            oe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ch_q <= ch_d;
            nch_q <= nch_d;
            bank_q <= bank_d;
            done_n_q <= done_n_d;
            ptr_q <= ptr_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
        end
    end

    // result memory left unreset: contents undefined at power-up
    // a word changes only at its channel's end, even mid-read; the bus keeps the copy taken at read fall
    always_ff @(posedge i_clock) begin
        if (wr_mem) begin
            mem_q[ch_q] <= smp; // RULE5 RULE15
        end
    end

    // ****************************************
    // result stream
    // ****************************************
    // stream drops results when full; pin readout is never stalled
    always_comb begin
        push_v = wr_mem && fifo_rdy;
    end
    // output register loads when empty or taken: one word beyond FIFO
    logic sv_q, sv_d;
    logic fv;
    logic [DW+1:0] fd;
    acp_fifo #(.WIDTH(DW + 2), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_wr_valid(push_v),
        .i_wr_data({ch_q, smp}),
        .o_wr_ready(fifo_rdy),
        .o_rd_valid(fv),
        .o_rd_data(fd),
        .i_rd_ready(!sv_q || i_stream_ready)
    );
    logic [DW+1:0] sd_q, sd_d;
    always_comb begin
        sv_d = sv_q;
        sd_d = sd_q;
        if (!sv_q || i_stream_ready) begin
            sv_d = fv;
            sd_d = fv ? fd : sd_q;
        end
    end
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sv_q <= 1'b0;
            sd_q <= '0;
        end else begin
            sv_q <= sv_d;
            sd_q <= sd_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // every output leaves straight from a register
    logic pd_q;
    logic hold_q;
    logic bankb_q;
    logic [1:0] act_q;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pd_q <= 1'b0;
            hold_q <= 1'b0;
            bankb_q <= 1'b0;
            act_q <= 2'h0;
        end else begin
            pd_q <= mode_d.pd; // RULE8
            hold_q <= (st_d == acp_pkg::ST_CONV);
            bankb_q <= (st_d == acp_pkg::ST_CONV) ? bank_d : mode_d.bank;
            act_q <= ch_d;
        end
    end
    assign o_power_down = pd_q;
    assign o_hold = hold_q;
    assign o_bank_b = bankb_q;
    assign o_active_channel = act_q;
    assign o_conv_done_n = done_n_q;
    assign o_result_data_bus = dout_q;
    assign o_result_data_oe = oe_q;
    assign o_stream_valid = sv_q;
    assign o_stream_data = sd_q;
endmodule : acp_ctrl
`default_nettype wire

//--- bench/acp_ctrl_chk.sv
// Purpose: port checker for acp_ctrl
// Assumes: pins held at least 3 cycles per level
// Notes: bound to acp_ctrl after the module
`timescale 1ns/1ps
`default_nettype none
module acp_ctrl_chk #(
    parameter int CONV_CYCLES = 4
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // pins
    input wire logic i_chip_select_n,
    input wire logic i_write_n,
    input wire logic i_read_n,
    input wire logic i_convert_start_n,
    input wire logic [3:0] i_control_word_bits,
    input wire logic o_conv_done_n,
    input wire logic o_result_data_oe,
    // status
    input wire logic o_power_down,
    input wire logic o_hold,
    input wire logic o_bank_b
);
    // ****
    // checks
    // ****
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic [11:0] hold_q;
    logic [11:0] hold_d;
    always_comb hold_d = o_hold ? hold_q + 12'h001 : 12'h000;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) hold_q <= 12'h000;
        else hold_q <= hold_d;
    end
    sequence s_wr_end;
        $rose(i_write_n | i_chip_select_n) &&
            $past(!i_write_n && !i_chip_select_n);
    endsequence
    sequence s_last_done;
        $fell(o_hold) && !o_power_down;
    endsequence
    AST_RESET_STATE: assert property ($rose(i_rst_n) |->
        o_conv_done_n && !o_power_down && !o_bank_b && !o_hold)
        else $error("state after reset wrong");
    AST_PD_ENTRY: assert property (
        s_wr_end ##0 i_control_word_bits[3] |-> ##[1:6] o_power_down)
        else $error("power-down not entered");
    AST_WAKE: assert property (
        s_wr_end ##0 !i_control_word_bits[3] |-> ##[1:6] !o_power_down)
        else $error("wake-up missing");
    AST_BANK: assert property (
        s_wr_end ##0 (i_control_word_bits[3:2] == 2'h1) |-> ##[1:6] o_bank_b)
        else $error("bank select missing");
    AST_PD_IDLE: assert property (
        o_power_down && $past(o_power_down) |-> !o_hold)
        else $error("converting in power-down");
    AST_START: assert property ($rose(i_convert_start_n) &&
        !o_power_down && !o_hold && o_conv_done_n |-> ##[1:6] o_hold)
        else $error("start not taken");
    AST_DONE: assert property (s_last_done |-> ##[0:2] !o_conv_done_n)
        else $error("done not flagged");
    AST_CONV_TIME: assert property (s_last_done |->
        hold_q >= CONV_CYCLES && hold_q <= 4 * CONV_CYCLES + 8)
        else $error("conversion time wrong");
    AST_READ_DONE: assert property ($fell(i_read_n) &&
        !i_chip_select_n && !o_conv_done_n |-> ##[1:6] o_conv_done_n)
        else $error("read did not clear done");
    AST_OE: assert property (
        o_result_data_oe == $past(!i_read_n && !i_chip_select_n, 3))
        else $error("data bus enable wrong");
endmodule : acp_ctrl_chk
bind acp_ctrl acp_ctrl_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
    .i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_chip_select_n(i_chip_select_n), .i_write_n(i_write_n),
    .i_read_n(i_read_n), .i_convert_start_n(i_convert_start_n),
    .i_control_word_bits(i_control_word_bits),
    .o_conv_done_n(o_conv_done_n), .o_result_data_oe(o_result_data_oe),
    .o_power_down(o_power_down),
    .o_hold(o_hold), .o_bank_b(o_bank_b));
`default_nettype wire

//--- bench/acp_host.sv
// Purpose: host processor model on the strobed bus
// Assumes: every level held 4 cycles or more
// Notes: pins change 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
module acp_host (
    // clock and data bus
    input wire logic i_clock,
    input wire logic [13:0] i_data,
    // strobes and control word
    output logic o_cs_n,
    output logic o_wr_n,
    output logic o_rd_n,
    output logic o_cst_n,
    output logic [3:0] o_word
);
    initial begin
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_cst_n = 1'b1;
        o_word = 4'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick
    task automatic write_word(input logic [3:0] w);
        o_cs_n = 1'b0;
        o_word = w;
        tick(4);
        o_wr_n = 1'b0;
        tick(4);
        o_wr_n = 1'b1;
        tick(8);
        o_cs_n = 1'b1;
        // released lines must not keep the last value
        o_word = ~w;
    endtask : write_word
    task automatic pulse_start();
        o_cst_n = 1'b0;
        tick(4);
        o_cst_n = 1'b1;
        tick(4);
    endtask : pulse_start
    logic [13:0] got [4];
    logic [13:0] got_lat;
    task automatic read_seq(input int n, input logic [1:0] sel);
        o_cs_n = 1'b0;
        tick(4);
        for (int k = 0; k < n; k++) begin
            o_rd_n = 1'b0;
            tick(6);
            got[k] = i_data;
            if (k == sel) got_lat = i_data;
            o_rd_n = 1'b1;
            tick(4);
        end
        o_cs_n = 1'b1;
        tick(4);
    endtask : read_seq
endmodule : acp_host
`default_nettype wire

//--- bench/testbench.sv
// Purpose: self-checking bench for acp_ctrl
// Assumes: conversion shortened to 4 cycles
// Notes: rows hold {control word, channel count}
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [55:0] BANK_A = {14'h3FFF, 14'h2000, 14'h1FFF, 14'h0001};
    localparam logic [55:0] BANK_B = {14'h0ABC, 14'h3555, 14'h0123, 14'h2AAA};
    localparam logic [6:0] ROWS [8] = '{7'h01, 7'h0A, 7'h13, 7'h1C,
        7'h21, 7'h2A, 7'h33, 7'h3C};
    logic i_clock, i_rst_n, cs_n, wr_n, rd_n, cst_n, done_n, pd, hold;
    logic bank_b, st_valid, st_ready;
    logic [3:0] word;
    logic [13:0] data;
    logic [1:0] act;
    logic oe;
    logic [55:0] smp_a, smp_b;
    logic [15:0] st_data;
    int error_cnt = 0;
    int n_tests = 0;
    int n;
    acp_ctrl #(.CONV_CYCLES(4), .FIFO_DEPTH(32)) dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_chip_select_n(cs_n),
        .i_write_n(wr_n), .i_read_n(rd_n), .i_convert_start_n(cst_n),
        .i_control_word_bits(word), .o_result_data_bus(data),
        .o_result_data_oe(oe), .o_conv_done_n(done_n),
        .i_sample_bank_a(smp_a), .i_sample_bank_b(smp_b),
        .o_power_down(pd), .o_hold(hold), .o_bank_b(bank_b),
        .o_active_channel(act), .o_stream_valid(st_valid),
        .o_stream_data(st_data), .i_stream_ready(st_ready));
    acp_host host (.i_clock(i_clock), .i_data(data), .o_cs_n(cs_n),
        .o_wr_n(wr_n), .o_rd_n(rd_n), .o_cst_n(cst_n), .o_word(word));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic do_reset();
        i_rst_n = 1'b0;
        host.tick(3);
        i_rst_n = 1'b1;
        check({13'h0, done_n, pd, bank_b}, 16'h0004);
        host.tick(1000);
    endtask : do_reset
    task automatic convert(input logic [6:0] row, input logic [1:0] sel);
        logic [55:0] bank;
        int i;
        bank = row[5] ? smp_b : smp_a;
        host.pulse_start();
        for (i = 0; i < 200 && done_n !== 1'b0; i++)
            host.tick(1);
        if (i == 200) begin
            error_cnt++;
            complete_run();
        end
        host.read_seq(row[2:0], sel);
        for (int k = 0; k < row[2:0]; k++)
            check({2'h0, host.got[k]}, {2'h0, bank[14*k+:14]});
        check({2'h0, host.got_lat}, {2'h0, bank[14*sel+:14]});
        check({15'h0, done_n}, 16'h0001);
        check({15'h0, oe}, 16'h0000);
        check({14'h0, act}, {14'h0, 2'(row[2:0] - 3'h1)});
    endtask : convert
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    initial begin
        st_ready = 1'b0;
        smp_a = BANK_A;
        smp_b = BANK_B;
        do_reset();
        // ****
        // every powered-up mode (control words 0 to 7), stream stalled
        // ****
        for (int r = 0; r < 8; r++) begin
            host.write_word(ROWS[r][6:3]);
            check({15'h0, bank_b}, {15'h0, ROWS[r][5]});
            convert(ROWS[r], 2'(r % ROWS[r][2:0]));
        end
        // 36 results offered: FIFO depth plus the output register kept
        host.write_word(4'h3);
        repeat (4) convert(7'h1C, 2'h3);
        check(st_data, {2'h0, BANK_A[13:0]});
        st_ready = 1'b1;
        n = 0;
        for (int i = 0; i < 40; i++) begin
            if (st_valid === 1'b1) n++;
            host.tick(1);
        end
        check(16'(n), 16'(acp_pkg::FIFO_DEPTH + 1));
        check({15'h0, st_valid}, 16'h0000);
        // ****
        // power-down, wake, reset mid-conversion
        // ****
        host.write_word(4'hF);
        check({15'h0, pd}, 16'h0001);
        host.tick(20);
        check({14'h0, pd, hold}, 16'h0002);
        host.write_word(4'h7);
        check({14'h0, pd, bank_b}, 16'h0001);
        host.tick(1000);
        smp_b = ~BANK_B;
        convert(7'h3C, 2'h2);
        host.pulse_start();
        do_reset();
        convert(7'h01, 2'h0);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
